// *** inc/dsw_pkg.sv ***
`default_nettype none
package dsw_pkg;

  // Object indices on the object-access port
  localparam logic [15:0] DSW_IDX_STATE_WORD = 16'h6041;
  localparam logic [15:0] DSW_IDX_CONTROL_WORD = 16'h6040;

  // Drive state word bit positions
  localparam int DSW_B_READY = 0;
  localparam int DSW_B_SWITCHED_ON = 1;
  localparam int DSW_B_OP_ENABLED = 2;
  localparam int DSW_B_FAULT = 3;
  localparam int DSW_B_DC_READY = 4;
  localparam int DSW_B_QSTOP_N = 5;
  localparam int DSW_B_OP_INHIBIT = 6;
  localparam int DSW_B_WARNING = 7;
  localparam int DSW_B_RX_OFF = 8;
  localparam int DSW_B_NET_ACCEPT = 9;
  localparam int DSW_B_IN_WINDOW = 10;
  localparam int DSW_B_LIMIT = 11;
  localparam int DSW_B_FOLLOWS = 12;
  localparam int DSW_B_FOLLOW_ERR = 13;
  localparam int DSW_B_BRAKE_REL = 14;
  localparam int DSW_B_SAFE_INACTIVE = 15;

  // Control word bit positions
  localparam int DSW_C_SWITCH_ON = 0;
  localparam int DSW_C_VOLTAGE = 1;
  localparam int DSW_C_QSTOP_N = 2;
  localparam int DSW_C_ENABLE_OP = 3;
  localparam int DSW_C_FAULT_RESET = 7;

  // Operating mode code of the manufacturer velocity mode (-2)
  localparam logic [7:0] DSW_MODE_MS_VELOCITY = 8'hFE;

  localparam logic [15:0] DSW_WORD_RESET = 16'h0000;
  localparam logic [15:0] DSW_CTRL_RESET = 16'h0000;

  typedef enum logic [3:0] {
    DSW_ST_INIT,
    DSW_ST_INHIBIT,
    DSW_ST_READY,
    DSW_ST_SWITCHED_ON,
    DSW_ST_OP_ENABLED,
    DSW_ST_QUICK_STOP,
    DSW_ST_FAULT_REACTION,
    DSW_ST_TROUBLE
  } dsw_state_e;

  typedef enum logic [2:0] {
    DSW_CMD_NONE,
    DSW_CMD_DISABLE_VOLTAGE,
    DSW_CMD_QUICK_STOP,
    DSW_CMD_SHUTDOWN,
    DSW_CMD_SWITCH_ON,
    DSW_CMD_ENABLE_OP
  } dsw_cmd_e;

endpackage
`default_nettype wire

// *** design/dsw_encoder.sv ***
// Functional notes
// - Read-only 16-bit state word; bit 0 set when drive ready to start.
// - Bit 1 set while the drive is switched on.
// - Bit 3 set while a fault or trouble condition is active.
// - Bit 4 set when the DC bus is ready for operation.
// - Bit 5 is low while a quick stop is in progress.
// - Bit 6 set in switch-on inhibited and in trouble.
// - Bit 8 set when cyclic process-data reception is deactivated.
// - Bit 9 set when the drive can accept network commands.
// - Bit 9 held low in manufacturer velocity mode, code -2.
// - Bit 10 set while actual speed lies inside the target window.
// - Bit 11 set while an internal limit clamps a setpoint.
// - Bit 12 set only in operation enabled without test mode or internal setpoint.
// - Bit 13 set while a following error is present.
// - Bit 14 set while the holding brake is released.
// - Bit 15 low when safety disabled the power stage, else high.
// - After power-up: initialising, no access, brake closed, operation inhibited.
// - Initialising reports bits 0, 1, 2, 3 and 6 as zero.
// - After initialisation go to switch-on inhibited; access allowed, operation inhibited.
// - Fieldbus operational or process-data control deselected also enters switch-on inhibited.
// - Switch-on inhibited: brake closed under internal control, bit 6 high, bits 0-3 low.
// - Fault-reset rising edge clears a gone fault, enters switch-on inhibited.
// - Bit 7 shows a warning; warnings never change state, need no reset.
`timescale 1ns/1ps
`default_nettype none
module dsw_encoder (
  input wire logic ref_clk,
  input wire logic reset,
  // Object-access port of the fieldbus stack
  input wire logic rd_req,
  input wire logic [15:0] rd_index,
  output logic rd_valid,
  output logic rd_error,
  output logic [15:0] rd_data,
  input wire logic wr_req,
  input wire logic [15:0] wr_index,
  input wire logic [15:0] wr_data,
  output logic wr_ack,
  output logic wr_error,
  // Drive status from on-chip logic
  input wire logic init_done,
  input wire logic fieldbus_operational,
  input wire logic pd_control_deselect,
  input wire logic dc_bus_ready,
  input wire logic warning_active,
  input wire logic fault_event,
  input wire logic fault_cause_active,
  input wire logic standstill,
  input wire logic cyclic_rx_off_flag,
  input wire logic [7:0] op_mode,
  input wire logic speed_in_window,
  input wire logic limit_active,
  input wire logic test_mode_active,
  input wire logic internal_setpoint_active,
  input wire logic following_error,
  input wire logic brake_released_fb,
  input wire logic brake_ctrl_internal,
  input wire logic brake_ext_release,
  // Safety power-stage disable, asynchronous pin
  input wire logic safety_disable_pin,
  // Drive outputs
  output logic [15:0] drive_state_word,
  output logic brake_release_cmd,
  output logic pulse_enable,
  output logic comm_allowed
);

  typedef struct packed {
    dsw_pkg::dsw_state_e state;
    logic [15:0] word;
    logic [15:0] ctrl_word;
    logic rd_valid;
    logic rd_error;
    logic [15:0] rd_data;
    logic wr_ack;
    logic wr_error;
    logic brake_release_cmd;
    logic pulse_enable;
    logic comm_allowed;
    logic safe_meta;
    logic safe_sync;
    logic fb_op_prev;
    logic fault_reset_prev;
  } dsw_regs_s;

  localparam dsw_regs_s DSW_REGS_RESET = '{
    state: dsw_pkg::DSW_ST_INIT,
    word: dsw_pkg::DSW_WORD_RESET,
    ctrl_word: dsw_pkg::DSW_CTRL_RESET,
    rd_valid: 1'b0,
    rd_error: 1'b0,
    rd_data: dsw_pkg::DSW_WORD_RESET,
    wr_ack: 1'b0,
    wr_error: 1'b0,
    brake_release_cmd: 1'b0,
    pulse_enable: 1'b0,
    comm_allowed: 1'b0,
    safe_meta: 1'b0,
    safe_sync: 1'b0,
    fb_op_prev: 1'b0,
    fault_reset_prev: 1'b0
  };

  dsw_regs_s r;
  dsw_regs_s next_r;

  // Control word to device command, standard profile decoding
  function automatic dsw_pkg::dsw_cmd_e dsw_decode(input logic [15:0] cw);
    dsw_pkg::dsw_cmd_e cmd;
    cmd = dsw_pkg::DSW_CMD_NONE;
    if (!cw[dsw_pkg::DSW_C_VOLTAGE]) begin
      cmd = dsw_pkg::DSW_CMD_DISABLE_VOLTAGE;
    end else if (!cw[dsw_pkg::DSW_C_QSTOP_N]) begin
      cmd = dsw_pkg::DSW_CMD_QUICK_STOP;
    end else if (!cw[dsw_pkg::DSW_C_SWITCH_ON]) begin
      cmd = dsw_pkg::DSW_CMD_SHUTDOWN;
    end else if (!cw[dsw_pkg::DSW_C_ENABLE_OP]) begin
      cmd = dsw_pkg::DSW_CMD_SWITCH_ON;
    end else begin
      cmd = dsw_pkg::DSW_CMD_ENABLE_OP;
    end
    return cmd;
  endfunction

  function automatic logic dsw_powered(input dsw_pkg::dsw_state_e st);
    return (st == dsw_pkg::DSW_ST_OP_ENABLED) || (st == dsw_pkg::DSW_ST_QUICK_STOP) ||
           (st == dsw_pkg::DSW_ST_FAULT_REACTION);
  endfunction

  always_comb begin
    dsw_pkg::dsw_cmd_e cmd;
    logic fault_reset_edge;
    logic force_inhibit;
    logic [15:0] w;
    cmd = dsw_decode(r.ctrl_word);
    w = '0;
    fault_reset_edge = r.ctrl_word[dsw_pkg::DSW_C_FAULT_RESET] && !r.fault_reset_prev;
    force_inhibit = (fieldbus_operational && !r.fb_op_prev) || pd_control_deselect;
    next_r = r;

    // Safety pin: two flops before use
    next_r.safe_meta = safety_disable_pin;
    next_r.safe_sync = r.safe_meta;

    next_r.fb_op_prev = fieldbus_operational;
    next_r.fault_reset_prev = r.ctrl_word[dsw_pkg::DSW_C_FAULT_RESET];

    // Warnings never enter this machine, so they cannot change state
    case (r.state)
      dsw_pkg::DSW_ST_INIT: begin
        if (init_done) begin
          next_r.state = dsw_pkg::DSW_ST_INHIBIT;
        end
      end
      dsw_pkg::DSW_ST_INHIBIT: begin
        if (fault_event) begin
          next_r.state = dsw_pkg::DSW_ST_TROUBLE;
        end else if (!force_inhibit && cmd == dsw_pkg::DSW_CMD_SHUTDOWN) begin
          next_r.state = dsw_pkg::DSW_ST_READY;
        end
      end
      dsw_pkg::DSW_ST_READY, dsw_pkg::DSW_ST_SWITCHED_ON, dsw_pkg::DSW_ST_OP_ENABLED,
      dsw_pkg::DSW_ST_QUICK_STOP: begin
        if (fault_event) begin
          next_r.state = dsw_powered(r.state) ? dsw_pkg::DSW_ST_FAULT_REACTION :
                                                dsw_pkg::DSW_ST_TROUBLE;
        end else if (force_inhibit || cmd == dsw_pkg::DSW_CMD_DISABLE_VOLTAGE) begin
          // deselect or bus start drops back
          next_r.state = dsw_pkg::DSW_ST_INHIBIT;
        end else if (cmd == dsw_pkg::DSW_CMD_QUICK_STOP) begin
          next_r.state = (r.state == dsw_pkg::DSW_ST_OP_ENABLED ||
                          r.state == dsw_pkg::DSW_ST_QUICK_STOP) ?
                         dsw_pkg::DSW_ST_QUICK_STOP : dsw_pkg::DSW_ST_INHIBIT;
        end else if (r.state == dsw_pkg::DSW_ST_QUICK_STOP) begin
          // Only enable operation ends a quick stop
          if (cmd == dsw_pkg::DSW_CMD_ENABLE_OP) begin
            next_r.state = dsw_pkg::DSW_ST_OP_ENABLED;
          end
        end else if (cmd == dsw_pkg::DSW_CMD_SHUTDOWN) begin
          next_r.state = dsw_pkg::DSW_ST_READY;
        end else if (cmd == dsw_pkg::DSW_CMD_SWITCH_ON) begin
          next_r.state = dsw_pkg::DSW_ST_SWITCHED_ON;
        end else if (cmd == dsw_pkg::DSW_CMD_ENABLE_OP &&
                     r.state != dsw_pkg::DSW_ST_READY) begin
          next_r.state = dsw_pkg::DSW_ST_OP_ENABLED;
        end
      end
      dsw_pkg::DSW_ST_FAULT_REACTION: begin
        // Controlled stop first, then trouble
        if (standstill) begin
          next_r.state = dsw_pkg::DSW_ST_TROUBLE;
        end
      end
      dsw_pkg::DSW_ST_TROUBLE: begin
        // reset only once the cause is gone
        if (fault_reset_edge && !fault_cause_active) begin
          next_r.state = dsw_pkg::DSW_ST_INHIBIT;
        end
      end
      default: begin
        next_r.state = dsw_pkg::DSW_ST_INIT;
      end
    endcase

    // no access and no power while initialising
    next_r.comm_allowed = (next_r.state != dsw_pkg::DSW_ST_INIT);
    // pulses stay inhibited on reset; only powered states enable them
    next_r.pulse_enable = dsw_powered(next_r.state);
    // brake closed under internal control unless operation enabled
    if (next_r.state == dsw_pkg::DSW_ST_INIT) begin
      next_r.brake_release_cmd = 1'b0;
    end else if (brake_ctrl_internal) begin
      next_r.brake_release_cmd = (next_r.state == dsw_pkg::DSW_ST_OP_ENABLED);
    end else begin
      next_r.brake_release_cmd = brake_ext_release;
    end

    w[dsw_pkg::DSW_B_READY] = (next_r.state != dsw_pkg::DSW_ST_INIT) &&
                              (next_r.state != dsw_pkg::DSW_ST_INHIBIT) &&
                              (next_r.state != dsw_pkg::DSW_ST_TROUBLE);
    w[dsw_pkg::DSW_B_SWITCHED_ON] = w[dsw_pkg::DSW_B_READY] &&
                                    (next_r.state != dsw_pkg::DSW_ST_READY);
    w[dsw_pkg::DSW_B_OP_ENABLED] = dsw_powered(next_r.state);
    w[dsw_pkg::DSW_B_FAULT] = (next_r.state == dsw_pkg::DSW_ST_FAULT_REACTION) ||
                              (next_r.state == dsw_pkg::DSW_ST_TROUBLE);
    w[dsw_pkg::DSW_B_DC_READY] = dc_bus_ready;
    w[dsw_pkg::DSW_B_QSTOP_N] = (next_r.state != dsw_pkg::DSW_ST_QUICK_STOP);
    // operation inhibited, low bits follow state
    w[dsw_pkg::DSW_B_OP_INHIBIT] = (next_r.state == dsw_pkg::DSW_ST_INHIBIT) ||
                                   (next_r.state == dsw_pkg::DSW_ST_TROUBLE);
    w[dsw_pkg::DSW_B_WARNING] = warning_active;
    w[dsw_pkg::DSW_B_RX_OFF] = cyclic_rx_off_flag;
    w[dsw_pkg::DSW_B_NET_ACCEPT] = next_r.comm_allowed &&
                                   (op_mode != dsw_pkg::DSW_MODE_MS_VELOCITY);
    w[dsw_pkg::DSW_B_IN_WINDOW] = speed_in_window;
    w[dsw_pkg::DSW_B_LIMIT] = limit_active;
    w[dsw_pkg::DSW_B_FOLLOWS] = (next_r.state == dsw_pkg::DSW_ST_OP_ENABLED) &&
                                !test_mode_active && !internal_setpoint_active;
    w[dsw_pkg::DSW_B_FOLLOW_ERR] = following_error;
    w[dsw_pkg::DSW_B_BRAKE_REL] = brake_released_fb;
    w[dsw_pkg::DSW_B_SAFE_INACTIVE] = !r.safe_sync;
    next_r.word = w;

    // Object access answers one cycle after the request
    next_r.rd_valid = 1'b0;
    next_r.rd_error = 1'b0;
    next_r.wr_ack = 1'b0;
    next_r.wr_error = 1'b0;
    if (rd_req) begin
      if (r.comm_allowed && rd_index == dsw_pkg::DSW_IDX_STATE_WORD) begin
        next_r.rd_valid = 1'b1;
        next_r.rd_data = r.word;
      end else if (r.comm_allowed && rd_index == dsw_pkg::DSW_IDX_CONTROL_WORD) begin
        next_r.rd_valid = 1'b1;
        next_r.rd_data = r.ctrl_word;
      end else begin
        next_r.rd_error = 1'b1;
      end
    end
    if (wr_req) begin
      // state word is read-only; writes refused in init
      if (r.comm_allowed && wr_index == dsw_pkg::DSW_IDX_CONTROL_WORD) begin
        next_r.wr_ack = 1'b1;
        next_r.ctrl_word = wr_data;
      end else begin
        next_r.wr_error = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= DSW_REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign drive_state_word = r.word;
  assign rd_valid = r.rd_valid;
  assign rd_error = r.rd_error;
  assign rd_data = r.rd_data;
  assign wr_ack = r.wr_ack;
  assign wr_error = r.wr_error;
  assign brake_release_cmd = r.brake_release_cmd;
  assign pulse_enable = r.pulse_enable;
  assign comm_allowed = r.comm_allowed;

endmodule
`default_nettype wire

// *** bench/dsw_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsw_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rd_req,
  input wire logic [15:0] rd_index,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [15:0] rd_data,
  input wire logic wr_req,
  input wire logic [15:0] wr_index,
  input wire logic wr_error,
  input wire logic dc_bus_ready,
  input wire logic warning_active,
  input wire logic [7:0] op_mode,
  input wire logic test_mode_active,
  input wire logic internal_setpoint_active,
  input wire logic brake_ctrl_internal,
  input wire logic safety_disable_pin,
  input wire logic [15:0] drive_state_word,
  input wire logic brake_release_cmd,
  input wire logic comm_allowed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_dc_bit_copy: assert property (
    !$past(reset) |-> drive_state_word[4] == $past(dc_bus_ready))
    else $error("dc bus bit does not follow its input");
  a_warn_bit_copy: assert property (
    !$past(reset) |-> drive_state_word[7] == $past(warning_active))
    else $error("warning bit does not follow its input");
  a_mode_net_off: assert property (
    !$past(reset) && $past(op_mode) == 8'hFE |-> !drive_state_word[9])
    else $error("network bit set in velocity mode");
  a_init_bits_low: assert property (
    !comm_allowed |-> drive_state_word[3:0] == 4'h0 && !drive_state_word[6])
    else $error("init state word pattern wrong");
  a_inhibit_no_run: assert property (
    drive_state_word[6] |-> drive_state_word[2:0] == 3'h0)
    else $error("inhibited yet running bits set");
  a_follow_needs_op: assert property (
    drive_state_word[12] |-> drive_state_word[2] && !$past(test_mode_active) &&
    !$past(internal_setpoint_active))
    else $error("follow bit set without enabled operation");
  a_read_word_ok: assert property (
    rd_req && rd_index == 16'h6041 && comm_allowed |=>
    rd_valid && !rd_error && rd_data == $past(drive_state_word))
    else $error("state word read answered wrongly");
  a_write_ro_word: assert property (
    wr_req && wr_index == 16'h6041 |=> wr_error)
    else $error("write to state word not refused");
  a_safe_bit_low: assert property (
    safety_disable_pin [*4] |=> !drive_state_word[15])
    else $error("safety bit not cleared");
  a_init_no_read: assert property (
    rd_req && !comm_allowed |=> rd_error && !rd_valid)
    else $error("read served during init");
  a_brake_held: assert property (
    drive_state_word[6] && $past(brake_ctrl_internal) |-> !brake_release_cmd)
    else $error("brake released while inhibited");
endmodule
bind dsw_encoder dsw_chk u_chk (.*);
`default_nettype wire

// *** bench/dsw_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsw_master (
  input wire logic ref_clk,
  output logic rd_req,
  output logic [15:0] rd_index,
  input wire logic rd_valid,
  input wire logic rd_error,
  input wire logic [15:0] rd_data,
  output logic wr_req,
  output logic [15:0] wr_index,
  output logic [15:0] wr_data,
  input wire logic wr_ack,
  input wire logic wr_error
);
  initial begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    {rd_index, wr_index, wr_data} = 48'h0;
  end
  // Lines are inverted after each request so stale values never pass
  task automatic rd(input logic [15:0] idx, output logic ok, output logic bad,
                    output logic [15:0] d);
    @(negedge ref_clk);
    rd_req = 1'b1;
    rd_index = idx;
    @(negedge ref_clk);
    rd_req = 1'b0;
    rd_index = ~idx;
    ok = rd_valid;
    bad = rd_error;
    d = rd_data;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] v, output logic ok,
                    output logic bad);
    @(negedge ref_clk);
    wr_req = 1'b1;
    wr_index = idx;
    wr_data = v;
    @(negedge ref_clk);
    wr_req = 1'b0;
    wr_index = ~idx;
    wr_data = ~v;
    ok = wr_ack;
    bad = wr_error;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rd_req, rd_valid, rd_error, wr_req, wr_ack, wr_error, ok, bad;
  logic [15:0] rd_index, rd_data, wr_index, wr_data, drive_state_word, d;
  logic init_done, fieldbus_operational, pd_control_deselect, dc_bus_ready, warning_active;
  logic fault_event, fault_cause_active, standstill, cyclic_rx_off_flag, speed_in_window;
  logic limit_active, test_mode_active, internal_setpoint_active, following_error;
  logic brake_released_fb, brake_ctrl_internal, brake_ext_release, safety_disable_pin;
  logic brake_release_cmd, pulse_enable, comm_allowed;
  logic [7:0] op_mode;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 34017;
  dsw_encoder DUT (.*);
  dsw_master m (.*);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task final_report;
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] exp_word(input dsw_pkg::dsw_state_e st);
    logic [15:0] w;
    w = 16'h0020;
    {w[4], w[7], w[8], w[10]} = {dc_bus_ready, warning_active, cyclic_rx_off_flag,
                                 speed_in_window};
    {w[11], w[13], w[14]} = {limit_active, following_error, brake_released_fb};
    w[15] = !safety_disable_pin;
    w[9] = st != dsw_pkg::DSW_ST_INIT && op_mode != 8'hFE;
    case (st)
      dsw_pkg::DSW_ST_INHIBIT: w[6] = 1'b1;
      dsw_pkg::DSW_ST_READY: w[0] = 1'b1;
      dsw_pkg::DSW_ST_SWITCHED_ON: w[1:0] = 2'h3;
      dsw_pkg::DSW_ST_OP_ENABLED: w[2:0] = 3'h7;
      dsw_pkg::DSW_ST_QUICK_STOP: {w[5], w[2:0]} = 4'h7;
      dsw_pkg::DSW_ST_TROUBLE: {w[6], w[3]} = 2'h3;
      default: ;
    endcase
    w[12] = st == dsw_pkg::DSW_ST_OP_ENABLED && !test_mode_active && !internal_setpoint_active;
    return w;
  endfunction
  task rnd;
    {dc_bus_ready, warning_active, cyclic_rx_off_flag, speed_in_window, limit_active,
     following_error, brake_released_fb, test_mode_active, internal_setpoint_active,
     brake_ctrl_internal, brake_ext_release, safety_disable_pin} = 12'($random(seed));
    op_mode = (2'($random(seed)) == 2'h0) ? dsw_pkg::DSW_MODE_MS_VELOCITY : 8'($random(seed));
  endtask
  task chk_st(input dsw_pkg::dsw_state_e st);
    logic [15:0] e;
    logic [15:0] g;
    logic br, run, live;
    repeat (4) @(negedge ref_clk);
    e = exp_word(st);
    g = drive_state_word;
    live = st != dsw_pkg::DSW_ST_INIT;
    run = st == dsw_pkg::DSW_ST_OP_ENABLED || st == dsw_pkg::DSW_ST_QUICK_STOP;
    br = live && (brake_ctrl_internal ? st == dsw_pkg::DSW_ST_OP_ENABLED : brake_ext_release);
    cmp("word bits 3-0", e & 16'h000F, g & 16'h000F);
    cmp("word bits 7-4", e & 16'h00F0, g & 16'h00F0);
    cmp("word bits 15-8", e & 16'hFF00, g & 16'hFF00);
    cmp("brake", {15'h0, br}, {15'h0, brake_release_cmd});
    cmp("pulses", {15'h0, run}, {15'h0, pulse_enable});
    cmp("comm", {15'h0, live}, {15'h0, comm_allowed});
    m.rd(dsw_pkg::DSW_IDX_STATE_WORD, ok, bad, d);
    cmp("read status", {14'h0, live, !live}, {14'h0, ok, bad});
    if (!live) cmp("init read", 16'h1, {15'h0, bad});
    else cmp("read data", e, d);
  endtask
  task wr(input logic [15:0] v, input dsw_pkg::dsw_state_e st);
    rnd();
    safety_disable_pin = 1'b0;
    m.wr(dsw_pkg::DSW_IDX_CONTROL_WORD, v, ok, bad);
    cmp("write ack", 16'h1, {15'h0, ok});
    chk_st(st);
  endtask
  initial begin
    {init_done, fieldbus_operational, pd_control_deselect, fault_event, fault_cause_active} = 5'h0;
    standstill = 1'b0;
    rnd();
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) begin
      rnd();
      chk_st(dsw_pkg::DSW_ST_INIT);
      m.wr(dsw_pkg::DSW_IDX_CONTROL_WORD, 16'h0006, ok, bad);
      cmp("init write", 16'h1, {15'h0, bad});
    end
    init_done = 1'b1;
    for (int i = 0; i < 12; i++) begin
      rnd();
      if (i == 0) op_mode = dsw_pkg::DSW_MODE_MS_VELOCITY;
      if (i == 1) {safety_disable_pin, brake_ctrl_internal} = 2'h3;
      chk_st(dsw_pkg::DSW_ST_INHIBIT);
      m.rd(16'h1234, ok, bad, d);
      cmp("bad index", 16'h1, {15'h0, bad});
      m.wr(dsw_pkg::DSW_IDX_STATE_WORD, 16'h000F, ok, bad);
      cmp("ro write", 16'h1, {15'h0, bad});
    end
    wr(16'h0006, dsw_pkg::DSW_ST_READY);
    wr(16'h0007, dsw_pkg::DSW_ST_SWITCHED_ON);
    wr(16'h000F, dsw_pkg::DSW_ST_OP_ENABLED);
    fault_event = 1'b1;
    @(negedge ref_clk);
    fault_event = 1'b0;
    standstill = 1'b1;
    chk_st(dsw_pkg::DSW_ST_TROUBLE);
    fault_cause_active = 1'b1;
    wr(16'h0080, dsw_pkg::DSW_ST_TROUBLE);
    wr(16'h0000, dsw_pkg::DSW_ST_TROUBLE);
    fault_cause_active = 1'b0;
    wr(16'h0080, dsw_pkg::DSW_ST_INHIBIT);
    wr(16'h0006, dsw_pkg::DSW_ST_READY);
    pd_control_deselect = 1'b1;
    chk_st(dsw_pkg::DSW_ST_INHIBIT);
    // Deselect gone: stored shutdown command moves on to ready by itself
    pd_control_deselect = 1'b0;
    wr(16'h0007, dsw_pkg::DSW_ST_SWITCHED_ON);
    wr(16'h000F, dsw_pkg::DSW_ST_OP_ENABLED);
    wr(16'h000B, dsw_pkg::DSW_ST_QUICK_STOP);
    wr(16'h000F, dsw_pkg::DSW_ST_OP_ENABLED);
    fieldbus_operational = 1'b1;
    chk_st(dsw_pkg::DSW_ST_INHIBIT);
    final_report();
  end
endmodule
`default_nettype wire
